//--- shared/acs_defines.svh
// Register offsets, field positions, reset values and timing counts
// of the converter sequencer. Assumes inclusion by bare name.
`ifndef ACS_DEFINES_SVH
`define ACS_DEFINES_SVH

// Word-aligned byte offsets on the register bus.
`define ACS_OFF_CTRL   8'h00
`define ACS_OFF_CLKSEL 8'h04
`define ACS_OFF_RESL   8'h08
`define ACS_OFF_RESH   8'h0c
`define ACS_OFF_STAT   8'h10
`define ACS_OFF_CLR    8'h14
`define ACS_OFF_EN     8'h18

// Field positions inside the control word.
`define ACS_CTRL_START 0
`define ACS_CTRL_EOC   1
`define ACS_CTRL_CHAN  2
`define ACS_CTRL_PSEL  5

// Field positions inside the enable word.
`define ACS_EN_ADC     0
`define ACS_EN_GLB     1

// Reset value of the conversion pending flag.
`define ACS_EOC_RST    1'b1

// Conversion length in converter clock periods.
`define ACS_LEN_8BIT   76'd64
`define ACS_LEN_9BIT   76'd76

// Last count of the divider for each clock-select code.
`define ACS_DIV2_LAST  5'd1
`define ACS_DIV8_LAST  5'd7
`define ACS_DIV32_LAST 5'd31

`endif

//--- shared/acs_pkg.sv
// Types shared by the converter sequencer and its clock divider.
// Assumes acs_defines.svh is on the include path.
`include "acs_defines.svh"

package acs_pkg;

    // Sequencer states.
    typedef enum logic [1:0] {
        ACS_IDLE = 2'b00,
        ACS_HELD = 2'b01,
        ACS_RUN  = 2'b10
    } acs_state_type;

    // Whole state of the sequencer.
    typedef struct packed {
        logic          ack;
        logic [31:0]   rdat;
        logic          start;
        logic          prev;
        logic [2:0]    chan;
        logic [2:0]    psel;
        logic [1:0]    csel;
        logic          eoc;
        acs_state_type st;
        logic [6:0]    cnt;
        logic [8:0]    res;
        logic          flag;
        logic          en_adc;
        logic          en_glb;
        logic          pwr;
        logic [3:0]    pins;
        logic          core_rst;
        logic          irq;
        logic [8:0]    sar1;
        logic [8:0]    sar2;
    } acs_seq_type;

    // Whole state of the divider.
    typedef struct packed {
        logic [4:0] cnt;
        logic       tick;
    } acs_div_type;

    // Last divider count for a clock-select code.
    function automatic logic [4:0] acs_div_last(input logic [1:0] sel);
        unique case (sel)
            2'b00:   acs_div_last = `ACS_DIV2_LAST;
            2'b01:   acs_div_last = `ACS_DIV8_LAST;
            default: acs_div_last = `ACS_DIV32_LAST;
        endcase
    endfunction : acs_div_last

endpackage : acs_pkg

//--- src/acs_clkdiv.sv
// Converter clock divider: one tick per converter clock period.
// Assumes the caller holds run_i low outside a conversion.
`timescale 1ns/1ns

module acs_clkdiv
    import acs_pkg::*;
(
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    input  wire logic       ce_i,
    input  wire logic [1:0] csel_i,
    input  wire logic       run_i,
    output logic            tick_o
);

    acs_div_type q;   // Registered state.
    acs_div_type d;   // Next state.

    // Count system clocks; a tick closes each period.
    always_comb begin
        d      = q;
        d.tick = 1'b0;
        if (!run_i) begin
            // Restart so the first period is a whole one.
            d.cnt = 5'd0;
        end else if (q.cnt >= acs_div_last(csel_i)) begin
            // Divide by 2, 8 or 32; code 11 acts as 32.
            d.cnt  = 5'd0;
            d.tick = 1'b1;
        end else begin
            d.cnt = q.cnt + 5'd1;
        end
    end

    // Register the state; a low enable freezes it.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            q <= '0;
        end else if (ce_i) begin
            q <= d;
        end
    end

    assign tick_o = q.tick;

    // Ticks never come back to back at the slowest rate.
    AST_DIV32_GAP: assert property (@(posedge clk_i) disable iff (rst_i)
        q.tick && csel_i == 2'b10 && $stable(csel_i) |=> !q.tick)
        else $error("Divider ticked twice in a row at divide by 32.");

endmodule : acs_clkdiv

//--- src/acs_top.sv
// Conversion sequencer for a successive-approximation converter,
// reached over a classic Wishbone slave with 32-bit data.
// Assumes the analog core and the CPU stack sit on clk_i.
//
// Behaviour
// - Falling step of start pulse launches conversion.
// - Pending flag drops low at completion.
// - Result registers readable once flag low.
// - Interrupt needs both enables, stack not full.
// - Length 64 or 76 converter periods.
// - Converter clock divides by 2, 8, 32.
// - Conversion runs without stalling the processor.
// - Pin select zero frees pins, powers down.
// - Start held high resets core, flag one.
// - Pin select four or more: all analog.
// - Completion sets converter interrupt request flag.
//
// Design decisions made here: the placing of the registers and register access over Wishbone.
`timescale 1ns/1ns

module acs_top
    import acs_pkg::*;
#(
    parameter int RES_BITS = 8   // Converter resolution, 8 or 9.
) (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        ce_i,
    input  wire logic        cyc_i,
    input  wire logic        stb_i,
    input  wire logic        we_i,
    input  wire logic [7:0]  adr_i,
    input  wire logic [3:0]  sel_i,
    input  wire logic [31:0] dat_i,
    output logic      [31:0] dat_o,
    output logic             ack_o,
    input  wire logic        stack_full_i,
    input  wire logic [8:0]  sar_data_i,
    output logic             irq_o,
    output logic             core_power_o,
    output logic             core_reset_o,
    output logic      [3:0]  pin_analog_o,
    output logic      [2:0]  channel_o,
    output logic             conv_tick_o
);

    // Conversion length in converter clock periods.
    localparam logic [75:0] LEN_WIDE =
        (RES_BITS == 9) ? `ACS_LEN_9BIT : `ACS_LEN_8BIT;
    localparam logic [6:0] LEN_LAST = LEN_WIDE[6:0] - 7'd1;

    // Refuse resolutions the sequencer cannot serve.
    if (RES_BITS != 8 && RES_BITS != 9) begin : g_bad_res
        $error("RES_BITS must be 8 or 9.");
    end

    acs_seq_type q;      // Registered state.
    acs_seq_type d;      // Next state.
    logic        tick;   // One pulse per converter clock period.
    logic        req;    // A bus cycle awaits its answer.
    logic        wr;     // Bus write carrying the low byte lane.
    logic        rise;   // Start bit went from zero to one.
    logic        fall;   // Start bit went from one to zero.
    logic        clr;    // Software clear of the request flag.

    // Converter clock divider, running only during a conversion.
    acs_clkdiv acs_clkdiv_i (
        .clk_i  (clk_i),
        .rst_i  (rst_i),
        .ce_i   (ce_i),
        .csel_i (q.csel),
        .run_i  (q.st == ACS_RUN),
        .tick_o (tick)
    );

    // Bus decode, sequencer and output terms.
    always_comb begin
        d     = q;
        d.ack = 1'b0;

        // A classic cycle is answered one edge after it starts.
        req   = cyc_i && stb_i && !q.ack;
        wr    = req && we_i && sel_i[0];
        d.ack = req;

        // Read data; unmapped offsets read as zero.
        d.rdat = 32'h0000_0000;
        if (req && !we_i) begin
            unique case (adr_i)
                `ACS_OFF_CTRL: begin
                    d.rdat[`ACS_CTRL_START]      = q.start;
                    d.rdat[`ACS_CTRL_EOC]        = q.eoc;
                    d.rdat[`ACS_CTRL_CHAN +: 3] = q.chan;
                    d.rdat[`ACS_CTRL_PSEL +: 3] = q.psel;
                end
                `ACS_OFF_CLKSEL: begin
                    d.rdat[1:0] = q.csel;
                end
                `ACS_OFF_RESL: begin
                    d.rdat[7:0] = q.res[7:0];
                end
                `ACS_OFF_RESH: begin
                    d.rdat[0] = q.res[8];
                end
                `ACS_OFF_STAT: begin
                    d.rdat[0] = q.flag;
                end
                `ACS_OFF_EN: begin
                    d.rdat[`ACS_EN_ADC] = q.en_adc;
                    d.rdat[`ACS_EN_GLB] = q.en_glb;
                end
                default: begin
                    d.rdat = 32'h0000_0000;
                end
            endcase
        end

        // Register writes; the pending flag is read only.
        clr = 1'b0;
        if (wr) begin
            unique case (adr_i)
                `ACS_OFF_CTRL: begin
                    d.start = dat_i[`ACS_CTRL_START];
                    d.chan  = dat_i[`ACS_CTRL_CHAN +: 3];
                    d.psel  = dat_i[`ACS_CTRL_PSEL +: 3];
                end
                `ACS_OFF_CLKSEL: begin
                    d.csel = dat_i[1:0];
                end
                `ACS_OFF_STAT: begin
                    // Writing zero clears the request flag.
                    clr = !dat_i[0];
                end
                `ACS_OFF_CLR: begin
                    // Writing one clears the request flag.
                    clr = dat_i[0];
                end
                `ACS_OFF_EN: begin
                    d.en_adc = dat_i[`ACS_EN_ADC];
                    d.en_glb = dat_i[`ACS_EN_GLB];
                end
                default: begin
                    d.csel = q.csel;
                end
            endcase
        end
        if (clr) begin
            d.flag = 1'b0;
        end

        // Edges of the software start bit.
        d.prev = q.start;
        rise   = q.start && !q.prev;
        fall   = !q.start && q.prev;

        // Two-stage capture of the analog core's result.
        d.sar1 = sar_data_i;
        d.sar2 = q.sar1;

        // Conversion sequencer.
        if (rise) begin
            // A rising start resets the core from any state.
            d.st  = ACS_HELD;
            d.eoc = 1'b1;
            d.cnt = 7'd0;
        end else begin
            unique case (q.st)
                ACS_IDLE: begin
                    d.st = ACS_IDLE;
                end
                ACS_HELD: begin
                    // Stay in reset until start returns low.
                    if (fall && q.psel != 3'b000) begin
                        d.st  = ACS_RUN;
                        d.cnt = 7'd0;
                    end else if (fall) begin
                        d.st = ACS_IDLE;
                    end
                end
                ACS_RUN: begin
                    // Runs alone in the background; the bus stays free.
                    if (q.psel == 3'b000) begin
                        // Power cut abandons the conversion.
                        d.st = ACS_IDLE;
                    end else if (tick && q.cnt == LEN_LAST) begin
                        // Result and flag change on the same edge.
                        d.res = (RES_BITS == 9) ? q.sar2 : {1'b0, q.sar2[7:0]};
                        d.eoc = 1'b0;
                        // The set is applied after any clear.
                        d.flag = 1'b1;
                        d.st   = ACS_IDLE;
                    end else if (tick) begin
                        d.cnt = q.cnt + 7'd1;
                    end
                end
                default: begin
                    d.st = ACS_IDLE;
                end
            endcase
        end

        // Pins: zero frees all, one to three grows, four or more all.
        if (d.psel >= 3'd4) begin
            d.pins = 4'hf;
        end else begin
            d.pins = 4'(4'hf >> (3'd4 - d.psel));
        end
        d.pwr      = (d.psel != 3'b000);
        d.core_rst = (d.st == ACS_HELD) || !d.pwr;
        // Offer the interrupt only when it can be taken.
        d.irq = d.flag && d.en_adc && d.en_glb && !stack_full_i;
    end

    // Register the whole state; a low enable freezes it.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            q     <= '0;
            q.eoc <= `ACS_EOC_RST;
            q.st  <= ACS_IDLE;
        end else if (ce_i) begin
            q <= d;
        end
    end

    // Every output comes from a state flip-flop.
    assign dat_o        = q.rdat;
    assign ack_o        = q.ack;
    assign irq_o        = q.irq;
    assign core_power_o = q.pwr;
    assign core_reset_o = q.core_rst;
    assign pin_analog_o = q.pins;
    assign channel_o    = q.chan;
    assign conv_tick_o  = tick;

    // A rising start sets the flag and holds the core.
    AST_RISE_HOLDS: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i && q.start && !q.prev |=> q.eoc && q.st == ACS_HELD)
        else $error("Rising start did not hold the converter.");

    // Falling start launches the conversion when powered.
    AST_FALL_LAUNCH: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i && q.st == ACS_HELD && !q.start && q.prev && q.psel != 3'b000
        |=> q.st == ACS_RUN)
        else $error("Falling start did not launch a conversion.");

    // While held, the core is in reset and the flag is one.
    AST_HELD_RESET: assert property (@(posedge clk_i) disable iff (rst_i)
        q.st == ACS_HELD |-> q.eoc && core_reset_o)
        else $error("Held state without core reset or flag.");

    // Flag drops only out of a run, together with the request.
    AST_EOC_DONE: assert property (@(posedge clk_i) disable iff (rst_i)
        $fell(q.eoc) |-> $past(q.st) == ACS_RUN && q.flag)
        else $error("Pending flag fell outside a completed run.");

    // Completion comes at the last converter period.
    AST_LENGTH: assert property (@(posedge clk_i) disable iff (rst_i)
        $fell(q.eoc) |-> $past(q.cnt) == LEN_LAST)
        else $error("Conversion ended at the wrong length.");

    // Results move only with the falling flag.
    AST_RES_ATOMIC: assert property (@(posedge clk_i) disable iff (rst_i)
        !$fell(q.eoc) |-> $stable(q.res))
        else $error("Result changed without completion.");

    // Pin select zero frees pins and cuts power.
    AST_POWER_OFF: assert property (@(posedge clk_i) disable iff (rst_i)
        q.psel == 3'b000 |-> !core_power_o && pin_analog_o == 4'h0)
        else $error("Converter powered with no pins selected.");

    // Four or more selects all pins.
    AST_ALL_PINS: assert property (@(posedge clk_i) disable iff (rst_i)
        q.psel >= 3'd4 |-> pin_analog_o == 4'hf)
        else $error("Not all pins analog for select four or more.");

    // Interrupt only with flag and both enables.
    AST_IRQ_GATED: assert property (@(posedge clk_i) disable iff (rst_i)
        irq_o |-> q.flag && q.en_adc && q.en_glb)
        else $error("Interrupt raised without flag or enables.");

    // Bus answer lasts one cycle.
    AST_ACK_PULSE: assert property (@(posedge clk_i) disable iff (rst_i)
        ack_o |=> !ack_o)
        else $error("Acknowledge held longer than one cycle.");

    // A conversion completes.
    COV_DONE: cover property (@(posedge clk_i) disable iff (rst_i)
        $fell(q.eoc));

    // An interrupt is offered.
    COV_IRQ: cover property (@(posedge clk_i) disable iff (rst_i)
        $rose(irq_o));

    // A run is restarted by a new rising start.
    COV_RESTART: cover property (@(posedge clk_i) disable iff (rst_i)
        q.st == ACS_RUN ##1 q.st == ACS_HELD);

endmodule : acs_top

//--- tb/acs_top_bench.sv
// Self-checking bench for the converter sequencer: Wishbone tasks and one task per scenario.
// Assumes acs_pkg is compiled first and acs_defines.svh is on the include path.
`timescale 1ns/1ns
`include "acs_defines.svh"
`define CHK(nm, ex, got) begin tests_run++; if ((got) !== (ex)) begin n_errors++; \
    $display("unexpected %s expected %h seen %h", nm, ex, got); end end

module acs_top_bench
    import acs_pkg::*;
();
    logic        clk_i        = 1'b0;   // System clock, 100 MHz.
    logic        rst_i        = 1'b1;   // Synchronous reset, held for 8 cycles.
    logic        ce_i         = 1'b1;   // Clock enable, kept on.
    logic        cyc_i        = 1'b0;   // Bus cycle.
    logic        stb_i        = 1'b0;   // Bus strobe.
    logic        we_i         = 1'b0;   // Bus direction.
    logic [7:0]  adr_i        = 8'h00;  // Bus address.
    logic [3:0]  sel_i        = 4'hf;   // Byte enables, all lanes.
    logic [31:0] dat_i        = 32'h0;  // Bus write data.
    logic        stack_full_i = 1'b0;   // Processor stack full.
    logic [8:0]  sar_data_i   = 9'h0;   // Analog core result.
    logic [31:0] dat_o;                 // Bus read data.
    logic        ack_o;                 // Bus acknowledge.
    logic        irq_o;                 // Interrupt request.
    logic        core_power_o;          // Analog power.
    logic        core_reset_o;          // Analog reset.
    logic [3:0]  pin_analog_o;          // Shared pins in analog use.
    logic [2:0]  channel_o;             // Input channel.
    logic        conv_tick_o;           // Converter clock tick.
    logic [31:0] rdat;                  // Data of the last read.
    logic [6:0]  n_ticks      = 7'd0;   // Running count of ticks seen, never cleared, wrapping at 128.
    logic [6:0]  gap          = 7'd0;   // Cycles since the last tick.
    logic [6:0]  gap_last     = 7'd0;   // Spacing of the two latest ticks.
    logic [7:0]  last_res     = 8'h00;  // Result of the last completed conversion.
    int          n_errors     = 0;      // Mismatches.
    int          tests_run    = 0;      // Comparisons.

    // The clock toggles every half period.
    always #5 clk_i = ~clk_i;

    // Ticks are counted and spaced at the falling edge, where the pulse is settled.
    always @(negedge clk_i) begin
        if (conv_tick_o === 1'b1) begin
            n_ticks  <= n_ticks + 7'd1;
            gap_last <= gap;
            gap      <= 7'd1;
        end else begin
            gap <= gap + 7'd1;
        end
    end

    acs_top #(.RES_BITS(8)) acs_top_i (
        .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
        .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
        .stack_full_i(stack_full_i), .sar_data_i(sar_data_i), .irq_o(irq_o),
        .core_power_o(core_power_o), .core_reset_o(core_reset_o), .pin_analog_o(pin_analog_o),
        .channel_o(channel_o), .conv_tick_o(conv_tick_o));

    // Prints the verdict and ends the run.
    task automatic tally_and_finish();
        if (n_errors == 0 && tests_run > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : tally_and_finish

    // One classic cycle: the request holds until the edge at which ack is seen high.
    // Only the watchdog ends a wait that never sees ack.
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i  <= w;
        adr_i <= a;
        dat_i <= d;
        do begin
            @(posedge clk_i);
        end while (ack_o !== 1'b1);
        rdat = dat_o;
        `CHK("bus ack", 1'b1, ack_o)
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        we_i  <= 1'b0;
    endtask : wb

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        wb(1'b1, a, d);
    endtask : wr

    task automatic rd(input logic [7:0] a);
        wb(1'b0, a, 32'h0);
    endtask : rd

    // Reset values and an unmapped read.
    task automatic t_reset();
        rd(`ACS_OFF_CTRL);
        `CHK("pending at reset", `ACS_EOC_RST, rdat[`ACS_CTRL_EOC])
        `CHK("pins at reset", 4'h0, pin_analog_o)
        rd(8'h1c);
        `CHK("unmapped read", 32'h0, rdat)
    endtask : t_reset

    // Every pin-select code, each change followed at once by a start pulse.
    // Codes go from highest to zero, so that no conversion is left running.
    task automatic t_pins();
        for (int p = 7; p >= 0; p--) begin
            wr(`ACS_OFF_CTRL, 32'(p << 5) | 32'h9);
            wr(`ACS_OFF_CTRL, 32'(p << 5) | 32'h8);
            repeat (2) @(negedge clk_i);
            `CHK("analog pins", (p >= 4) ? 4'hf : 4'((1 << p) - 1), pin_analog_o)
            `CHK("core power", p != 0, core_power_o)
            `CHK("channel", 3'h2, channel_o)
        end
    endtask : t_pins

    // A full conversion at one clock-select code, result checked against the analog input.
    task automatic t_conv(input logic [1:0] cs, input logic [6:0] div, input logic [8:0] sar);
        int n;
        logic [6:0] t0;
        sar_data_i <= sar;
        wr(`ACS_OFF_CLKSEL, {30'h0, cs});
        wr(`ACS_OFF_CTRL, 32'h85);
        t0 = n_ticks;
        rd(`ACS_OFF_CTRL);
        `CHK("pending while held", 1'b1, rdat[`ACS_CTRL_EOC])
        `CHK("core reset while held", 1'b1, core_reset_o)
        `CHK("no ticks before the fall", 7'd0, 7'(n_ticks - t0))
        wr(`ACS_OFF_CTRL, 32'h84);
        rd(`ACS_OFF_CTRL);
        `CHK("pending while running", 1'b1, rdat[`ACS_CTRL_EOC])
        rd(`ACS_OFF_RESL);
        `CHK("result held during run", last_res, rdat[7:0])
        n = 0;
        while (irq_o !== 1'b1 && n < 3000) begin
            @(negedge clk_i);
            n++;
        end
        `CHK("ticks per conversion", `ACS_LEN_8BIT, 76'(7'(n_ticks - t0)))
        `CHK("tick spacing", div, gap_last)
        rd(`ACS_OFF_CTRL);
        `CHK("pending after end", 1'b0, rdat[`ACS_CTRL_EOC])
        rd(`ACS_OFF_RESL);
        `CHK("result low", sar[7:0], rdat[7:0])
        rd(`ACS_OFF_RESH);
        `CHK("result high", 1'b0, rdat[0])
        rd(`ACS_OFF_STAT);
        `CHK("request flag", 1'b1, rdat[0])
        `CHK("interrupt", 1'b1, irq_o)
        last_res = sar[7:0];
        wr(`ACS_OFF_CLR, 32'h1);
        repeat (2) @(negedge clk_i);
        `CHK("interrupt after clear", 1'b0, irq_o)
    endtask : t_conv

    // Masking by the global enable and by a full stack, then a clear through the status word.
    task automatic t_mask();
        int n;
        wr(`ACS_OFF_EN, 32'h1);
        wr(`ACS_OFF_CLKSEL, 32'h0);
        wr(`ACS_OFF_CTRL, 32'h85);
        wr(`ACS_OFF_CTRL, 32'h84);
        n = 0;
        do begin
            rd(`ACS_OFF_CTRL);
            n++;
        end while (rdat[`ACS_CTRL_EOC] !== 1'b0 && n < 200);
        `CHK("pending falls when polled", 1'b0, rdat[`ACS_CTRL_EOC])
        `CHK("irq without global enable", 1'b0, irq_o)
        stack_full_i <= 1'b1;
        wr(`ACS_OFF_EN, 32'h3);
        repeat (2) @(negedge clk_i);
        `CHK("irq with stack full", 1'b0, irq_o)
        @(posedge clk_i);
        stack_full_i <= 1'b0;
        repeat (2) @(negedge clk_i);
        `CHK("irq once stack frees", 1'b1, irq_o)
        wr(`ACS_OFF_STAT, 32'h0);
        repeat (2) @(negedge clk_i);
        `CHK("irq after status clear", 1'b0, irq_o)
        rd(`ACS_OFF_STAT);
        `CHK("flag after status clear", 1'b0, rdat[0])
    endtask : t_mask

    // A start pulse with no pins selected must not run a conversion.
    // Clearing the select first needs no start pulse to power down.
    task automatic t_off();
        logic [6:0] t0;
        wr(`ACS_OFF_CTRL, 32'h0);
        repeat (2) @(negedge clk_i);
        `CHK("power after clearing select", 1'b0, core_power_o)
        wr(`ACS_OFF_CTRL, 32'h1);
        t0 = n_ticks;
        wr(`ACS_OFF_CTRL, 32'h0);
        repeat (100) @(negedge clk_i);
        `CHK("ticks when powered down", 7'd0, 7'(n_ticks - t0))
        `CHK("power when deselected", 1'b0, core_power_o)
        `CHK("pins when deselected", 4'h0, pin_analog_o)
        `CHK("core reset when off", 1'b1, core_reset_o)
    endtask : t_off

    // Main sequence: reset, then the scenarios in turn.
    initial begin
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        t_reset();
        t_pins();
        wr(`ACS_OFF_EN, 32'h3);
        t_conv(2'b00, 7'd2, 9'h0a5);
        t_conv(2'b01, 7'd8, 9'h15a);
        t_conv(2'b10, 7'd32, 9'h1c3);
        t_conv(2'b11, 7'd32, 9'h03c);
        t_mask();
        t_off();
        tally_and_finish();
    end

    // Watchdog well beyond the sum of all conversions.
    initial begin
        repeat (20000) @(posedge clk_i);
        n_errors++;
        tally_and_finish();
    end
endmodule : acs_top_bench
